// ---- logic/icwl_loader.sv ----
// init control word loader: catches the two per-port words from nvm, applies defaults
// assumes nvm reader presents word, word offset and a one-cycle valid pulse
`timescale 1ns/1ps
`default_nettype none
`include "icwl_map.svh"
module icwl_loader (
   input wire logic clk,
   input wire logic rstn,
   // nvm reader side
   input wire logic nvm_valid,
   input wire logic nvm_ok,
   input wire logic [7:0] nvm_offset,
   input wire logic [15:0] nvm_word,
   // port enables, from straps outside this clock
   input wire logic first_port_en,
   input wire logic second_port_en,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   // external loss of signal pins and serdes idle inputs, async
   input wire logic first_loss_of_signal_input,
   input wire logic second_loss_of_signal_input,
   input wire logic first_serdes_idle,
   input wire logic second_serdes_idle,
   // first port outputs
   output logic first_connection_energy_source,
   output logic first_signal_detect,
   output logic first_ctrl_ext_sfp_en,
   output logic first_sfp_pad_isolate,
   output logic first_flash_disable,
   output logic first_flash_bar_en,
   output logic [1:0] first_int_pin,
   output logic first_ctrl_apm,
   output logic first_wake_power_mgmt_enable,
   output logic [1:0] first_link_mode,
   output logic first_loaded,
   // second port outputs, plus the unused first port dummy
   output logic second_connection_energy_source,
   output logic second_signal_detect,
   output logic second_ctrl_ext_sfp_en,
   output logic second_sfp_pad_isolate,
   output logic second_flash_disable,
   output logic second_flash_bar_en,
   output logic [1:0] second_int_pin,
   output logic first_dummy_unused_never,
   output logic second_ctrl_apm,
   output logic second_wake_power_mgmt_enable,
   output logic [1:0] second_link_mode,
   output logic second_loaded
);
   // ==========================================================
   // input synchronisers
   logic [1:0] en_s1_r;
   logic [1:0] en_s2_r;
   logic [1:0] los_s1_r;
   logic [1:0] los_s2_r;
   logic [1:0] idle_s1_r;
   logic [1:0] idle_s2_r;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         en_s1_r <= 2'h0;
         en_s2_r <= 2'h0;
         los_s1_r <= 2'h0;
         los_s2_r <= 2'h0;
         idle_s1_r <= 2'h0;
         idle_s2_r <= 2'h0;
      end else begin
         en_s1_r <= {second_port_en, first_port_en};
         en_s2_r <= en_s1_r;
         los_s1_r <= {second_loss_of_signal_input, first_loss_of_signal_input};
         los_s2_r <= los_s1_r;
         idle_s1_r <= {second_serdes_idle, first_serdes_idle};
         idle_s2_r <= idle_s1_r;
      end
   end
   // only one of the two ports enabled
   wire single_port = en_s2_r[0] ^ en_s2_r[1];

   // ==========================================================
   // word capture, index 0 first port, 1 second port
   logic [15:0] word_r [2];
   logic [1:0] loaded_r;
   wire [1:0] nvm_hit;
   assign nvm_hit[0] = nvm_valid && nvm_ok && (nvm_offset == `ICWL_OFS_FIRST_PORT);
   assign nvm_hit[1] = nvm_valid && nvm_ok && (nvm_offset == `ICWL_OFS_SECOND_PORT);
   wire [1:0] reg_hit;
   assign reg_hit[0] = reg_wr && (reg_addr == `ICWL_REG_WORD_FIRST);
   assign reg_hit[1] = reg_wr && (reg_addr == `ICWL_REG_WORD_SECOND);
   wire reload = reg_wr && (reg_addr == `ICWL_REG_CTRL) && reg_wdata[0];

   icwl_pkg::icwl_cfg_t cfg [2];
   icwl_pkg::icwl_cfg_t eff [2];
   logic [1:0] sdet;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_port
         icwl_dec_if dif ();
         assign dif.word = word_r[g];
         assign dif.single_port = single_port;
         assign dif.is_first = (g == 0);
         icwl_decode u_dec (
            .d(dif.dec)
         );
         assign cfg[g] = dif.cfg;
         assign eff[g] = loaded_r[g] ? cfg[g] : icwl_pkg::icwl_cfg_t'{
            energy_src: `ICWL_DEF_ENERGY_SRC,
            sfp_en: `ICWL_DEF_SFP_EN,
            flash_dis: `ICWL_DEF_FLASH_DIS,
            intpin: (single_port || dif.is_first) ? `ICWL_DEF_INTPIN_FIRST
               : `ICWL_DEF_INTPIN_SECOND,
            apm_en: `ICWL_DEF_APM_EN,
            link_mode: icwl_pkg::icwl_link_t'(`ICWL_DEF_LINK_MODE)};
         assign sdet[g] = eff[g].energy_src ? ~los_s2_r[g] : ~idle_s2_r[g];
         always_ff @(posedge clk or negedge rstn) begin
            if (!rstn) begin
               word_r[g] <= 16'h0;
               loaded_r[g] <= 1'b0;
            end else if (nvm_hit[g] || reg_hit[g]) begin
               // a good word in the reload cycle wins, so it is never lost
               word_r[g] <= nvm_hit[g] ? nvm_word : reg_wdata;
               loaded_r[g] <= 1'b1;
            end else if (reload) begin
               loaded_r[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // output registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         first_connection_energy_source <= `ICWL_DEF_ENERGY_SRC;
         first_signal_detect <= 1'b0;
         first_ctrl_ext_sfp_en <= `ICWL_DEF_SFP_EN;
         first_sfp_pad_isolate <= 1'b1;
         first_flash_disable <= `ICWL_DEF_FLASH_DIS;
         first_flash_bar_en <= 1'b0;
         first_int_pin <= `ICWL_DEF_INTPIN_FIRST;
         first_ctrl_apm <= `ICWL_DEF_APM_EN;
         first_wake_power_mgmt_enable <= `ICWL_DEF_APM_EN;
         first_link_mode <= `ICWL_DEF_LINK_MODE;
         first_loaded <= 1'b0;
         first_dummy_unused_never <= 1'b0;
      end else begin
         first_connection_energy_source <= eff[0].energy_src;
         first_signal_detect <= sdet[0];
         first_ctrl_ext_sfp_en <= eff[0].sfp_en;
         first_sfp_pad_isolate <= ~eff[0].sfp_en;
         first_flash_disable <= eff[0].flash_dis;
         first_flash_bar_en <= ~eff[0].flash_dis;
         first_int_pin <= eff[0].intpin;
         first_ctrl_apm <= eff[0].apm_en;
         first_wake_power_mgmt_enable <= eff[0].apm_en;
         first_link_mode <= eff[0].link_mode;
         first_loaded <= loaded_r[0];
         first_dummy_unused_never <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         second_connection_energy_source <= `ICWL_DEF_ENERGY_SRC;
         second_signal_detect <= 1'b0;
         second_ctrl_ext_sfp_en <= `ICWL_DEF_SFP_EN;
         second_sfp_pad_isolate <= 1'b1;
         second_flash_disable <= `ICWL_DEF_FLASH_DIS;
         second_flash_bar_en <= 1'b0;
         second_int_pin <= `ICWL_DEF_INTPIN_SECOND;
         second_ctrl_apm <= `ICWL_DEF_APM_EN;
         second_wake_power_mgmt_enable <= `ICWL_DEF_APM_EN;
         second_link_mode <= `ICWL_DEF_LINK_MODE;
         second_loaded <= 1'b0;
      end else begin
         second_connection_energy_source <= eff[1].energy_src;
         second_signal_detect <= sdet[1];
         second_ctrl_ext_sfp_en <= eff[1].sfp_en;
         second_sfp_pad_isolate <= ~eff[1].sfp_en;
         second_flash_disable <= eff[1].flash_dis;
         second_flash_bar_en <= ~eff[1].flash_dis;
         second_int_pin <= eff[1].intpin;
         second_ctrl_apm <= eff[1].apm_en;
         second_wake_power_mgmt_enable <= eff[1].apm_en;
         second_link_mode <= eff[1].link_mode;
         second_loaded <= loaded_r[1];
      end
   end

   // ==========================================================
   // register read, data one cycle after strobe
   wire [15:0] status_word = {10'h0, single_port, en_s2_r, 1'b0, loaded_r};
   wire [15:0] rd_mux =
      (reg_addr == `ICWL_REG_WORD_FIRST) ? word_r[0] :
      (reg_addr == `ICWL_REG_WORD_SECOND) ? word_r[1] :
      (reg_addr == `ICWL_REG_STATUS) ? status_word : 16'h0;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 16'h0;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 16'h0;
      end
   end
endmodule
`default_nettype wire

// ---- inc/icwl_map.svh ----
// constants for the init control word loader: offsets, field positions, defaults
// assumes inclusion by bare name from the design files
`ifndef ICWL_MAP_SVH
`define ICWL_MAP_SVH

// nvm word offsets of the control word
`define ICWL_OFS_SECOND_PORT 8'h14
`define ICWL_OFS_FIRST_PORT 8'h24

// field positions inside the word
`define ICWL_BIT_ENERGY_SRC 15
`define ICWL_BIT_SFP_EN 14
`define ICWL_BIT_FLASH_DIS 13
`define ICWL_INTPIN_HI 12
`define ICWL_INTPIN_LO 11
`define ICWL_BIT_APM_EN 10
`define ICWL_LINK_HI 9
`define ICWL_LINK_LO 8

// documented defaults, held until a good read or a register write of the word
`define ICWL_DEF_ENERGY_SRC 1'h0
`define ICWL_DEF_SFP_EN 1'h0
`define ICWL_DEF_FLASH_DIS 1'h1
`define ICWL_DEF_INTPIN_FIRST 2'h0
`define ICWL_DEF_INTPIN_SECOND 2'h1
`define ICWL_DEF_APM_EN 1'h1
`define ICWL_DEF_LINK_MODE 2'h0

// register port map (software view)
`define ICWL_REG_WORD_SECOND 8'h14
`define ICWL_REG_WORD_FIRST 8'h24
`define ICWL_REG_STATUS 8'h30
`define ICWL_REG_CTRL 8'h34

// positions in target registers
`define ICWL_CTRL_EXT_SFP_BIT 25
`define ICWL_CTRL_APM_BIT 6
`define ICWL_WAKE_APM_BIT 0

`endif

// ---- inc/icwl_pkg.sv ----
// types shared by the init control word loader files
// assumes icwl_map.svh is on the include path
package icwl_pkg;
   typedef enum logic [1:0] {
      ICWL_LINK_COPPER = 2'h0,
      ICWL_LINK_SERDES_LEGACY = 2'h1,
      ICWL_LINK_SGMII = 2'h2,
      ICWL_LINK_SERDES = 2'h3
   } icwl_link_t;

   typedef struct packed {
      logic energy_src;
      logic sfp_en;
      logic flash_dis;
      logic [1:0] intpin;
      logic apm_en;
      icwl_link_t link_mode;
   } icwl_cfg_t;
endpackage

// ---- inc/icwl_dec_if.sv ----
// carrier between the loader top and its per-port word decoder
// assumes one instance per port, same clock
`timescale 1ns/1ps
`default_nettype none
interface icwl_dec_if;
   logic [15:0] word;
   logic single_port;
   logic is_first;
   icwl_pkg::icwl_cfg_t cfg;
   modport top (output word, output single_port, output is_first, input cfg);
   modport dec (input word, input single_port, input is_first, output cfg);
endinterface
`default_nettype wire

// ---- logic/icwl_decode.sv ----
// pure decode of one control word into the controller defaults
// assumes the word is stable, held by the caller
`timescale 1ns/1ps
`default_nettype none
`include "icwl_map.svh"
module icwl_decode (
   icwl_dec_if.dec d
);
   wire [1:0] pin_field = d.word[`ICWL_INTPIN_HI:`ICWL_INTPIN_LO];
   assign d.cfg.intpin = d.single_port ? 2'h0 : pin_field;
   assign d.cfg.energy_src = d.word[`ICWL_BIT_ENERGY_SRC];
   assign d.cfg.sfp_en = d.word[`ICWL_BIT_SFP_EN];
   assign d.cfg.flash_dis = d.word[`ICWL_BIT_FLASH_DIS];
   assign d.cfg.apm_en = d.word[`ICWL_BIT_APM_EN];
   assign d.cfg.link_mode = icwl_pkg::icwl_link_t'(d.word[`ICWL_LINK_HI:`ICWL_LINK_LO]);
endmodule
`default_nettype wire

// ---- test/icwl_nvm_model.sv ----
// eeprom side: hands one stored word per request to the loader
// assumes requests come from the bench, one per cycle
`timescale 1ns/1ps
`default_nettype none
module icwl_nvm_model (
   input wire logic clk,
   input wire logic req,
   input wire logic req_ok,
   input wire logic req_second,
   input wire logic [15:0] img_word,
   output logic nvm_valid,
   output logic nvm_ok,
   output logic [7:0] nvm_offset,
   output logic [15:0] nvm_word
);
   initial nvm_word = 16'h0;
   always @(posedge clk) begin
      nvm_valid <= req;
      nvm_ok <= req & req_ok;
      nvm_offset <= req_second ? 8'h14 : 8'h24;
      // idle bus toggles so no stale word can pass for data
      nvm_word <= req ? img_word : ~nvm_word;
   end
endmodule
`default_nettype wire

// ---- test/icwl_loader_properties.sv ----
// checker for the loader top ports
// assumes bound to icwl_loader, one clock
`timescale 1ns/1ps
`default_nettype none
module icwl_loader_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire logic nvm_valid,
   input wire logic nvm_ok,
   input wire logic [7:0] nvm_offset,
   input wire logic [15:0] nvm_word,
   input wire logic first_port_en,
   input wire logic second_port_en,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic first_loss_of_signal_input,
   input wire logic first_serdes_idle,
   input wire logic first_connection_energy_source,
   input wire logic first_signal_detect,
   input wire logic first_ctrl_ext_sfp_en,
   input wire logic first_sfp_pad_isolate,
   input wire logic first_flash_disable,
   input wire logic first_flash_bar_en,
   input wire logic [1:0] first_int_pin,
   input wire logic first_ctrl_apm,
   input wire logic first_wake_power_mgmt_enable,
   input wire logic [1:0] first_link_mode,
   input wire logic first_loaded,
   input wire logic [1:0] second_link_mode,
   input wire logic second_connection_energy_source
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_take1;
      nvm_valid && nvm_ok && nvm_offset == 8'h24 && !reg_wr;
   endsequence
   sequence s_take2;
      nvm_valid && nvm_ok && nvm_offset == 8'h14 && !reg_wr;
   endsequence
   a_first_fields: assert property (s_take1 |-> ##2
      first_link_mode == $past(nvm_word[9:8], 2) && first_ctrl_apm == $past(nvm_word[10], 2)
      && first_connection_energy_source == $past(nvm_word[15], 2)) else $error("first fields");
   a_second_fields: assert property (s_take2 |-> ##2
      second_link_mode == $past(nvm_word[9:8], 2)
      && second_connection_energy_source == $past(nvm_word[15], 2)) else $error("second fields");
   a_pad_isolate: assert property (
      first_sfp_pad_isolate != first_ctrl_ext_sfp_en) else $error("pad isolate");
   a_flash_bar: assert property (
      first_flash_bar_en != first_flash_disable) else $error("flash window");
   a_wake_copy: assert property (
      first_ctrl_apm == first_wake_power_mgmt_enable) else $error("wake copy");
   a_default_hold: assert property (!first_loaded |-> first_flash_disable
      && first_ctrl_apm && !first_ctrl_ext_sfp_en && first_link_mode == 2'h0
      && !first_connection_energy_source) else $error("defaults lost");
   a_load_cause: assert property ($rose(first_loaded) |->
      $past(nvm_valid && nvm_ok && nvm_offset == 8'h24 || reg_wr && reg_addr == 8'h24, 2))
      else $error("load without good word");
   a_single_inta: assert property ((first_port_en && !second_port_en)[*5] |->
      first_int_pin == 2'h0) else $error("single port pin");
   a_detect_src: assert property ((first_connection_energy_source ?
      first_loss_of_signal_input : first_serdes_idle)[*5] |-> !first_signal_detect)
      else $error("detect source");
   a_read_window: assert property (reg_rd ##1 !reg_rd |-> ##1 reg_rdata == 16'h0)
      else $error("read data held");
endmodule
`default_nettype wire

// ---- test/icwl_loader_bench.sv ----
// bench for the loader: nvm loads, register port, port enables, detect
// assumes model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module icwl_loader_bench;
   logic clk = 1'b0, rstn = 1'b0, req = 1'b0, req_ok = 1'b0, req_second = 1'b0;
   logic reg_wr = 1'b0, reg_rd = 1'b0, first_port_en = 1'b1, second_port_en = 1'b1;
   logic first_loss_of_signal_input = 1'b0, second_loss_of_signal_input = 1'b0;
   logic first_serdes_idle = 1'b0, second_serdes_idle = 1'b0, rd_d = 1'b0;
   logic [7:0] reg_addr = 8'h0;
   logic [15:0] reg_wdata = 16'h0, img_word = 16'h0, w;
   logic nvm_valid, nvm_ok, first_dummy_unused_never;
   logic [7:0] nvm_offset;
   logic [15:0] nvm_word, reg_rdata;
   logic first_connection_energy_source, first_signal_detect, first_ctrl_ext_sfp_en;
   logic first_sfp_pad_isolate, first_flash_disable, first_flash_bar_en, first_ctrl_apm;
   logic first_wake_power_mgmt_enable, first_loaded, second_loaded, second_ctrl_apm;
   logic second_connection_energy_source, second_signal_detect, second_ctrl_ext_sfp_en;
   logic second_sfp_pad_isolate, second_flash_disable, second_flash_bar_en;
   logic second_wake_power_mgmt_enable;
   logic [1:0] first_int_pin, second_int_pin, first_link_mode, second_link_mode;
   logic [15:0] exp_q[$];
   int seed = 12111, error_cnt = 0, checks = 0;
   icwl_loader uut (.*);
   icwl_nvm_model nvm (.*);
   always #12.5 clk = ~clk;
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic fchk(input logic sec, input logic [7:0] e);
      chk({8'h0, sec ? {second_connection_energy_source, second_ctrl_ext_sfp_en,
         second_flash_disable, second_int_pin, second_ctrl_apm, second_link_mode} :
         {first_connection_energy_source, first_ctrl_ext_sfp_en, first_flash_disable,
         first_int_pin, first_ctrl_apm, first_link_mode}}, {8'h0, e});
      chk({12'h0, sec ? {second_sfp_pad_isolate, second_flash_bar_en,
         second_wake_power_mgmt_enable} : {first_sfp_pad_isolate, first_flash_bar_en,
         first_wake_power_mgmt_enable}, first_dummy_unused_never},
         {12'h0, ~e[6], ~e[5], e[2], 1'b0});
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   task automatic ld(input logic sec, input logic ok, input logic [15:0] d);
      req <= 1'b1;
      req_ok <= ok;
      req_second <= sec;
      img_word <= d;
      @(posedge clk);
      req <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
   task automatic results;
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // read data stand only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_d)
         chk(reg_rdata, exp_q.pop_front());
      rd_d <= reg_rd;
   end
   initial begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      results();
   end
   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      fchk(1'b0, 8'h24);
      fchk(1'b1, 8'h2c);
      rd(8'h30, 16'h0018);
      $display("test defaults done");
      for (int lm = 0; lm < 4; lm++) begin
         w = 16'($random(seed));
         w[9:8] = lm[1:0];
         ld(1'b0, 1'b1, w);
         fchk(1'b0, w[15:8]);
         ld(1'b1, 1'b1, ~w);
         fchk(1'b1, ~w[15:8]);
         fchk(1'b0, w[15:8]);
      end
      chk({14'h0, second_loaded, first_loaded}, 16'h3);
      $display("test loads done");
      wr(8'h34, 16'h0001);
      repeat (3) @(posedge clk);
      ld(1'b0, 1'b0, 16'($random(seed)));
      fchk(1'b0, 8'h24);
      chk({14'h0, second_loaded, first_loaded}, 16'h0);
      rd(8'h30, 16'h0018);
      $display("test refused done");
      w = 16'($random(seed));
      wr(8'h24, w);
      rd(8'h24, w);
      // one edge apart: the read strobe is never written twice in one step
      @(posedge clk);
      rd(8'h50, 16'h0);
      repeat (2) @(posedge clk);
      fchk(1'b0, w[15:8]);
      $display("test registers done");
      second_port_en <= 1'b0;
      w = 16'($random(seed)) | 16'h9800;
      ld(1'b0, 1'b1, w);
      repeat (2) @(posedge clk);
      fchk(1'b0, {w[15:13], 2'h0, w[10:8]});
      first_loss_of_signal_input <= 1'b1;
      second_loss_of_signal_input <= 1'b1;
      second_serdes_idle <= 1'b1;
      repeat (5) @(posedge clk);
      chk({15'h0, first_signal_detect}, 16'h0);
      chk({15'h0, second_signal_detect}, 16'h0);
      first_loss_of_signal_input <= 1'b0;
      first_serdes_idle <= 1'b1;
      repeat (5) @(posedge clk);
      chk({15'h0, first_signal_detect}, 16'h1);
      $display("test single port done");
      results();
   end
endmodule
bind icwl_loader icwl_loader_properties chk_i (.*);
`default_nettype wire
